// File: irc_pkg.sv
package irc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] IRC_OFF_CTRL   = 8'h00;
	localparam logic [7:0] IRC_OFF_STATUS = 8'h04;
	localparam logic [7:0] IRC_OFF_CARR   = 8'h08;
	localparam logic [7:0] IRC_OFF_MTIME  = 8'h0c;
	localparam logic [7:0] IRC_OFF_COUNT  = 8'h10;
	localparam logic [7:0] IRC_OFF_PWR    = 8'h14;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int IRC_B_EN     = 0;
	localparam int IRC_B_MODE   = 1;
	localparam int IRC_B_POL    = 2;
	localparam int IRC_B_DATA   = 3;
	localparam int IRC_B_CFME   = 4;
	localparam int IRC_B_ENV    = 5;
	localparam int IRC_B_EDGE   = 7;
	localparam int IRC_B_RELOAD = 9;
	localparam int IRC_B_BURST  = 10;
	localparam int IRC_B_IE     = 11;
	localparam int IRC_B_DIV    = 12;
	localparam int IRC_CTRL_W   = 15;

	// Status and power-control fields
	localparam int IRC_B_IFLAG  = 0;
	localparam int IRC_B_OVF    = 1;
	localparam int IRC_B_MLEVEL = 0;
	localparam int IRC_B_MDRIVE = 1;

	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [IRC_CTRL_W-1:0] IRC_CTRL_RST = 15'h0000;
	localparam logic [15:0]           IRC_CARR_RST = 16'h0000;
	localparam logic [15:0]           IRC_MT_RST   = 16'h0000;
	localparam logic [15:0]           IRC_CNT_MAX  = 16'hffff;
	localparam logic [15:0]           IRC_MT_BURST = 16'h0001;
	localparam logic [1:0]            IRC_ENV_MOD  = 2'b01;
	localparam logic [1:0]            IRC_ENV_RAW  = 2'b10;
	localparam logic [1:0]            IRC_EDGE_FALL = 2'b00;
	localparam logic [1:0]            IRC_EDGE_RISE = 2'b01;
	localparam logic [1:0]            IRC_GAP_LIMIT = 2'b10;
	localparam int                    IRC_PRE_W    = 7;

	// Operating mode of the timer
	typedef enum logic [2:0] {
		IRC_MD_OFF = 3'b001,
		IRC_MD_TX  = 3'b010,
		IRC_MD_RX  = 3'b100
	} irc_mode_t;

endpackage

// File: irc_timer.sv
// Contract
// - Timer disabled: transmit pin level and driver come from two power-control bits.
// - Input clock is system clock divided by two to the divider field.
// - Carrier high lasts high byte plus one, low lasts low byte plus one.
// - Carrier timing, data and polarity are latched once per modulation interval.
// - Enabled timer idles the transmit pin at the polarity level.
// - Interval counter counts carrier cycles or input clocks per clock-source bit.
// - Data one sends carrier, inverted by polarity; data zero sends idle level except in envelope 10.
// - Transmit starts on enable with mode set, mode with enable, or both.
// - Transmit start loads counter from modulation time, then counts down.
// - At zero: reload, resample, update pin, set interval flag, interrupt if enabled.
// - Each transmit interval lasts modulation time plus one counting cycles.
// - Transmit stops when mode goes to receive or enable clears.
// - Envelope modes drive envelope pin with data bit, inverted by polarity.
// - Envelope 01 sends modulated carrier, 10 sends unmodulated carrier.
// - Receive runs with mode zero and enable; edge field qualifies events.
// - Receive counter starts from zero at first qualified event, counts up.
// - Later events store level, copy counter to modulation time, optional clear.
// - Counter rollover from maximum sets overflow flag; interrupt if enabled.
// - Receive continues until transmit mode is chosen or enable clears.
// - Burst mode disables capture; modulation time counts qualified edges.
// - Burst mode: two carrier cycles with no edge set interval flag.
// - Burst bit rising sets modulation time to one.
//
// The register offsets and the Wishbone interface to the registers were decided locally.
module irc_timer
	import irc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Infrared pins
	input  wire logic        ir_rx_pin_i,
	output logic             ir_tx_pin_o,
	output logic             ir_tx_pin_oe_o,
	output logic             envelope_out_pin_o,
	// Interrupt request
	output logic             ir_irq_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
		reg_hit = (adr[7:2] == off[7:2]);
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
	endfunction

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic [IRC_CTRL_W-1:0] ctrl;
	logic [15:0]           carrier_timing;
	logic [15:0]           modulation_time;
	logic [15:0]           interval_counter;
	logic                  modulation_data_bit;
	logic                  manual_tx_level;
	logic                  manual_tx_drive_en;
	logic                  interval_flag;
	logic                  counter_overflow_flag;
	logic [IRC_PRE_W-1:0]  pre_cnt;
	logic                  phase_hi;
	logic [7:0]            car_cnt;
	logic [15:0]           car_lat;
	logic                  data_lat;
	logic                  pol_lat;
	logic                  rx_meta;
	logic                  rx_sync;
	logic                  rx_prev;
	logic                  rx_started;
	logic [1:0]            gap_cnt;
	logic                  burst_q;
	irc_mode_t             mode;
	irc_mode_t             next_mode;

	// Control fields
	logic       ir_enable;
	logic       tx_mode_select;
	logic       tx_polarity;
	logic       count_clock_select;
	logic [1:0] envelope_select;
	logic [1:0] edge_select;
	logic       reload_on_edge;
	logic       burst_count_mode;
	logic       ir_interrupt_enable;
	logic [2:0] clock_divider;

	assign ir_enable           = ctrl[IRC_B_EN];
	assign tx_mode_select      = ctrl[IRC_B_MODE];
	assign tx_polarity         = ctrl[IRC_B_POL];
	assign count_clock_select  = ctrl[IRC_B_CFME];
	assign envelope_select     = ctrl[IRC_B_ENV+1:IRC_B_ENV];
	assign edge_select         = ctrl[IRC_B_EDGE+1:IRC_B_EDGE];
	assign reload_on_edge      = ctrl[IRC_B_RELOAD];
	assign burst_count_mode    = ctrl[IRC_B_BURST];
	assign ir_interrupt_enable = ctrl[IRC_B_IE];
	assign clock_divider       = ctrl[IRC_B_DIV+2:IRC_B_DIV];

	// ----------------------------------------------------------------
	// Bus access
	// ----------------------------------------------------------------
	logic bus_req;
	logic bus_wr;
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr  = bus_req && wb_we_i;

	logic wr_ctrl;
	logic wr_stat;
	logic wr_carr;
	logic wr_mt;
	logic wr_pwr;
	assign wr_ctrl = bus_wr && reg_hit(wb_adr_i, IRC_OFF_CTRL);
	assign wr_stat = bus_wr && reg_hit(wb_adr_i, IRC_OFF_STATUS) && wb_sel_i[0];
	assign wr_carr = bus_wr && reg_hit(wb_adr_i, IRC_OFF_CARR);
	assign wr_mt   = bus_wr && reg_hit(wb_adr_i, IRC_OFF_MTIME);
	assign wr_pwr  = bus_wr && reg_hit(wb_adr_i, IRC_OFF_PWR) && wb_sel_i[0];

	// Control word with the written bytes merged in
	logic [15:0] ctrl_wr;
	assign ctrl_wr = merge16({1'b0, ctrl}, wb_dat_i, wb_sel_i);

	// One wait state; unmapped words read zero and still acknowledge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h0000_0000;
			if (bus_req && !wb_we_i) begin
				if (reg_hit(wb_adr_i, IRC_OFF_CTRL))
					wb_dat_o <= {17'h0_0000, ctrl[IRC_CTRL_W-1:IRC_B_DATA+1],
						modulation_data_bit, ctrl[IRC_B_DATA-1:0]};
				else if (reg_hit(wb_adr_i, IRC_OFF_STATUS))
					wb_dat_o <= {30'h0000_0000, counter_overflow_flag, interval_flag};
				else if (reg_hit(wb_adr_i, IRC_OFF_CARR))
					wb_dat_o <= {16'h0000, carrier_timing};
				else if (reg_hit(wb_adr_i, IRC_OFF_MTIME))
					wb_dat_o <= {16'h0000, modulation_time};
				else if (reg_hit(wb_adr_i, IRC_OFF_COUNT))
					wb_dat_o <= {16'h0000, interval_counter};
				else if (reg_hit(wb_adr_i, IRC_OFF_PWR))
					wb_dat_o <= {30'h0000_0000, manual_tx_drive_en, manual_tx_level};
			end
		end
	end

	// Control and configuration words
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl           <= IRC_CTRL_RST;
			carrier_timing <= IRC_CARR_RST;
		end else begin
			if (wr_ctrl)
				ctrl <= ctrl_wr[IRC_CTRL_W-1:0];
			if (wr_carr)
				carrier_timing <= merge16(carrier_timing, wb_dat_i, wb_sel_i);
		end
	end

	// Manual pin control used only while the timer is off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			manual_tx_level    <= 1'b0;
			manual_tx_drive_en <= 1'b0;
		end else if (wr_pwr) begin
			manual_tx_level    <= wb_dat_i[IRC_B_MLEVEL];
			manual_tx_drive_en <= wb_dat_i[IRC_B_MDRIVE];
		end
	end

	// ----------------------------------------------------------------
	// Mode tracking
	// ----------------------------------------------------------------
	always_comb begin
		case ({ir_enable, tx_mode_select})
			2'b11:   next_mode = IRC_MD_TX;
			2'b10:   next_mode = IRC_MD_RX;
			default: next_mode = IRC_MD_OFF;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			mode <= IRC_MD_OFF;
		else
			mode <= next_mode;
	end

	logic tx_start;
	logic tx_run;
	logic rx_run;
	assign tx_start = (next_mode == IRC_MD_TX) && (mode != IRC_MD_TX);
	assign tx_run   = (next_mode == IRC_MD_TX) && (mode == IRC_MD_TX);
	assign rx_run   = (next_mode == IRC_MD_RX);

	// ----------------------------------------------------------------
	// Prescaler and carrier generator
	// ----------------------------------------------------------------
	logic ir_tick;
	logic car_end;
	logic cnt_tick;
	logic [IRC_PRE_W-1:0] pre_mask;
	assign pre_mask = IRC_PRE_W'((8'h01 << clock_divider) - 8'h01);
	assign ir_tick  = ((pre_cnt & pre_mask) == '0);
	assign car_end  = ir_tick && !phase_hi && (car_cnt == 8'h00);
	assign cnt_tick = count_clock_select ? ir_tick : car_end;

	always_ff @(posedge clk_i) begin
		if (rst_i || !ir_enable)
			pre_cnt <= '0;
		else
			pre_cnt <= pre_cnt + IRC_PRE_W'(1);
	end

	// Phase counter; a new latched timing takes effect at the next phase load
	always_ff @(posedge clk_i) begin
		if (rst_i || !ir_enable || tx_start) begin
			phase_hi <= 1'b1;
			car_cnt  <= carrier_timing[15:8];
		end else if (ir_tick) begin
			if (car_cnt == 8'h00) begin
				phase_hi <= !phase_hi;
				car_cnt  <= phase_hi ? car_lat[7:0] : car_lat[15:8];
			end else begin
				car_cnt <= car_cnt - 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit interval counter and latches
	// ----------------------------------------------------------------
	logic tx_bound;
	assign tx_bound = tx_run && cnt_tick && (interval_counter == 16'h0000);

	// Latching per interval lets frequency hop without glitching mid-interval
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			car_lat  <= IRC_CARR_RST;
			data_lat <= 1'b0;
			pol_lat  <= 1'b0;
		end else if (tx_start || tx_bound) begin
			car_lat  <= carrier_timing;
			data_lat <= modulation_data_bit;
			pol_lat  <= tx_polarity;
		end else if (!tx_run) begin
			car_lat  <= carrier_timing;
			pol_lat  <= tx_polarity;
		end
	end

	// ----------------------------------------------------------------
	// Receive edge detection (pin synchronised first)
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_meta <= 1'b1;                 // Pin idles high: no false edge after reset
			rx_sync <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			rx_meta <= ir_rx_pin_i;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
		end
	end

	logic rise;
	logic fall;
	logic qual;
	assign rise = rx_sync && !rx_prev;
	assign fall = !rx_sync && rx_prev;
	always_comb begin
		case (edge_select)
			IRC_EDGE_FALL: qual = rx_run && fall;
			IRC_EDGE_RISE: qual = rx_run && rise;
			default:       qual = rx_run && (rise || fall);
		endcase
	end

	logic rx_cap;
	logic gap_hit;
	logic rx_ovf;
	assign rx_cap  = rx_started && qual;
	assign gap_hit = rx_run && rx_started && burst_count_mode && car_end
		&& (gap_cnt == IRC_GAP_LIMIT - 2'b01);
	assign rx_ovf  = rx_run && rx_started && cnt_tick && (interval_counter == IRC_CNT_MAX)
		&& !(qual && reload_on_edge);

	always_ff @(posedge clk_i) begin
		if (rst_i || !rx_run)
			rx_started <= 1'b0;
		else if (qual)
			rx_started <= 1'b1;
	end

	// Carrier cycles since the last qualified edge, saturating
	always_ff @(posedge clk_i) begin
		if (rst_i || !rx_run || qual)
			gap_cnt <= 2'b00;
		else if (car_end && gap_cnt != IRC_GAP_LIMIT)
			gap_cnt <= gap_cnt + 2'b01;
	end

	// ----------------------------------------------------------------
	// Interval counter (down in transmit, up in receive)
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			interval_counter <= 16'h0000;
		end else if (tx_start) begin
			interval_counter <= modulation_time;
		end else if (tx_run && cnt_tick) begin
			if (interval_counter == 16'h0000)
				interval_counter <= modulation_time;
			else
				interval_counter <= interval_counter - 16'h0001;
		end else if (rx_run) begin
			if (qual && (!rx_started || reload_on_edge))
				interval_counter <= 16'h0000;
			else if (rx_started && cnt_tick)
				interval_counter <= interval_counter + 16'h0001;
		end
	end

	// Modulation time: captured or edge-counted by hardware, else software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			modulation_time <= IRC_MT_RST;
			burst_q         <= 1'b0;
		end else begin
			burst_q <= burst_count_mode;
			if (burst_count_mode && !burst_q)
				modulation_time <= IRC_MT_BURST;
			else if (rx_cap && !burst_count_mode)
				modulation_time <= interval_counter;
			else if (qual && burst_count_mode)
				modulation_time <= modulation_time + 16'h0001;
			else if (wr_mt)
				modulation_time <= merge16(modulation_time, wb_dat_i, wb_sel_i);
		end
	end

	// Data bit: software sets it for transmit, capture stores the pin level
	always_ff @(posedge clk_i) begin
		if (rst_i)
			modulation_data_bit <= 1'b0;
		else if (rx_cap && !burst_count_mode)
			modulation_data_bit <= rx_sync;
		else if (wr_ctrl && wb_sel_i[0])
			modulation_data_bit <= wb_dat_i[IRC_B_DATA];
	end

	// ----------------------------------------------------------------
	// Sticky flags; a hardware set beats a software clear
	// ----------------------------------------------------------------
	logic iflag_set;
	assign iflag_set = tx_bound || (rx_cap && !burst_count_mode) || gap_hit;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			interval_flag         <= 1'b0;
			counter_overflow_flag <= 1'b0;
		end else begin
			if (iflag_set)
				interval_flag <= 1'b1;
			else if (wr_stat && !wb_dat_i[IRC_B_IFLAG])
				interval_flag <= 1'b0;
			if (rx_ovf)
				counter_overflow_flag <= 1'b1;
			else if (wr_stat && !wb_dat_i[IRC_B_OVF])
				counter_overflow_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ir_irq_o <= 1'b0;
		else
			ir_irq_o <= ir_interrupt_enable
				&& (interval_flag || counter_overflow_flag);
	end

	// ----------------------------------------------------------------
	// Pin outputs
	// ----------------------------------------------------------------
	logic carrier_on;
	assign carrier_on = (envelope_select == IRC_ENV_RAW) ? 1'b1 : data_lat;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ir_tx_pin_o        <= 1'b0;
			ir_tx_pin_oe_o     <= 1'b0;
			envelope_out_pin_o <= 1'b0;
		end else if (!ir_enable) begin
			ir_tx_pin_o        <= manual_tx_level;
			ir_tx_pin_oe_o     <= manual_tx_drive_en;
			envelope_out_pin_o <= 1'b0;
		end else if (mode == IRC_MD_TX && tx_run) begin
			ir_tx_pin_oe_o <= 1'b1;
			ir_tx_pin_o    <= carrier_on ? (phase_hi ^ pol_lat) : pol_lat;
			if (envelope_select == IRC_ENV_MOD || envelope_select == IRC_ENV_RAW)
				envelope_out_pin_o <= data_lat ^ pol_lat;
			else
				envelope_out_pin_o <= 1'b0;
		end else begin
			ir_tx_pin_oe_o     <= 1'b1;
			ir_tx_pin_o        <= tx_polarity;
			envelope_out_pin_o <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_tx_zero;
		tx_bound;
	endsequence
	sequence s_reloaded;
		(interval_counter == $past(modulation_time)) && interval_flag;
	endsequence

	manual_pin_a: assert property (!ir_enable |=> ir_tx_pin_o == $past(manual_tx_level)
		&& ir_tx_pin_oe_o == $past(manual_tx_drive_en)) else $error("manual pin wrong");
	prescale_a: assert property ((clock_divider == 3'h0) && ir_enable |-> ir_tick)
		else $error("prescaler not passing clock");
	phase_swap_a: assert property (ir_enable && ir_tick && phase_hi && car_cnt == 8'h00
		&& !tx_start |=> !phase_hi && car_cnt == $past(car_lat[7:0]))
		else $error("carrier low phase load wrong");
	tx_start_a: assert property (tx_start |=> interval_counter == $past(modulation_time))
		else $error("start load wrong");
	tx_reload_a: assert property (s_tx_zero |=> s_reloaded)
		else $error("interval reload wrong");
	down_count_a: assert property (tx_run && cnt_tick && interval_counter != 16'h0000
		|=> interval_counter == $past(interval_counter) - 16'h0001)
		else $error("down count wrong");
	rx_idle_a: assert property (ir_enable && !tx_mode_select |=> ir_tx_pin_o == $past(tx_polarity)
		&& ir_tx_pin_oe_o) else $error("idle level wrong");
	tx_stop_a: assert property (mode == IRC_MD_TX && !(ir_enable && tx_mode_select)
		|-> !tx_run && !tx_bound) else $error("transmit not stopped");
	overflow_a: assert property (rx_ovf |=> counter_overflow_flag && interval_counter == 16'h0000)
		else $error("overflow missed");
	capture_a: assert property (rx_cap && !burst_count_mode && !$rose(burst_count_mode)
		|=> modulation_time == $past(interval_counter)) else $error("capture wrong");
	burst_one_a: assert property (burst_count_mode && !burst_q |=> modulation_time == 16'h0001)
		else $error("burst start value wrong");
	flag_hold_a: assert property (interval_flag && !(wr_stat && !wb_dat_i[IRC_B_IFLAG])
		|=> interval_flag) else $error("flag dropped");

endmodule

// File: irc_rx_model.sv
module irc_rx_model (
	// Clock
	input  wire logic       clk_i,
	// Bench control
	input  wire logic       run_i,
	input  wire logic [7:0] half_i,
	// Emitter side
	input  wire logic       tx_i,
	input  wire logic       oe_i,
	output logic            lit_o,
	// Receiver side
	output logic            rx_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt;
	// Emitter glows only while the pin is really driven
	assign lit_o = tx_i & oe_i;
	// Receiver idles high through its pull-up; bursts toggle every half_i+1 clocks
	always @(posedge clk_i) begin
		if (!run_i) begin
			rx_o <= 1'b1;
			cnt  <= 8'h00;
		end else if (cnt >= half_i) begin
			rx_o <= ~rx_o;
			cnt  <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule

// File: ir_carrier_modulation_timer_tb.sv
module ir_carrier_modulation_timer_tb
	import irc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, rst_i, cyc, stb, we, run, ack, tx, oe, env, irq, rx, lit;
	logic [7:0]  adr, half, h, l;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, q, e, m;
	logic [31:0] exq[$];
	logic [31:0] mq[$];
	int          failures, n_tests, hi, lo;
	irc_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .ir_rx_pin_i(rx), .ir_tx_pin_o(tx), .ir_tx_pin_oe_o(oe),
		.envelope_out_pin_o(env), .ir_irq_o(irq));
	irc_rx_model prt (.clk_i(clk_i), .run_i(run), .half_i(half), .tx_i(tx), .oe_i(oe),
		.lit_o(lit), .rx_o(rx));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Classic cycle: hold everything until ack is sampled, then release
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, sel, wdat} <= {1'b1, 1'b1, w, a, 4'hf, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		// A slave that never answers counts as a mismatch
		if (ack !== 1'b1)
			failures++;
		q = rdat;
		{cyc, stb, we} <= 3'b000;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
		exq.push_back(x);
		mq.push_back(k);
		wb(1'b0, a, 32'h0);
	endtask
	// Waits bounded so a stuck pin cannot hang the measurement
	task automatic meas();
		int n;
		n = 0;
		while (tx !== 1'b0 && n < 500) begin @(posedge clk_i); n++; end
		while (tx !== 1'b1 && n < 900) begin @(posedge clk_i); n++; end
		hi = 0;
		lo = 0;
		while (tx === 1'b1 && hi < 500) begin @(posedge clk_i); hi++; end
		while (tx === 1'b0 && lo < 500) begin @(posedge clk_i); lo++; end
	endtask
	task summarize;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Read monitor: oldest note against each read answer
	always @(posedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0 && exq.size() > 0) begin
			e = exq.pop_front();
			m = mq.pop_front();
			check("rdata", rdat & m, e);
		end
	end
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		repeat (90000) @(posedge clk_i);
		failures++;
		summarize();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{cyc, stb, we, run, adr, sel, wdat, half} = '0;
		failures = 0;
		n_tests = 0;
		rst_i = 1'b1;
		void'($urandom(41));
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values, then a write into a hole must read back zero
		exq.delete();
		for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0, 32'hffffffff);
		wr(8'h40, 32'hffff);
		rd(8'h40, 32'h0, 32'hffffffff);
		h = 8'($urandom % 6);
		l = 8'($urandom % 6);
		wr(IRC_OFF_CARR, {16'h0, h, l});
		rd(IRC_OFF_CARR, {16'h0, h, l}, 32'hffffffff);
		// Manual pin control while the timer is off
		wr(IRC_OFF_PWR, 32'h3);
		repeat (3) @(posedge clk_i);
		check("man_tx", {tx, oe, lit}, 3'b111);
		wr(IRC_OFF_PWR, 32'h2);
		repeat (3) @(posedge clk_i);
		check("man_tx0", {tx, oe, lit}, 3'b010);
		// Polarity idle with data zero, envelope shows inverted data
		wr(IRC_OFF_CTRL, 32'h27);
		repeat (6) @(posedge clk_i);
		check("idle_env", {tx, oe, env}, 3'b111);
		// Unmodulated carrier with data zero, inverted by polarity one
		wr(IRC_OFF_CTRL, 32'h47);
		meas();
		check("raw_hi", 32'(hi), 32'(l + 1));
		check("raw_lo", 32'(lo), 32'(h + 1));
		check("raw_env", env, 1'b1);
		// Carrier phases for divider settings 0 to 2, then the interval interrupt
		wr(IRC_OFF_MTIME, 32'h4);
		for (int d = 0; d < 3; d++) begin
			wr(IRC_OFF_CTRL, 32'h0);
			wr(IRC_OFF_CTRL, 32'h0b | (d << 12));
			meas();
			check("carr_hi", 32'(hi), 32'(h + 1) << d);
			check("carr_lo", 32'(lo), 32'(l + 1) << d);
		end
		wr(IRC_OFF_STATUS, 32'h0);
		wr(IRC_OFF_CTRL, 32'h80b);
		repeat (150) @(posedge clk_i);
		rd(IRC_OFF_STATUS, 32'h1, 32'h1);
		check("irq_on", irq, 1'b1);
		// Stop, clear flags by writing zero
		wr(IRC_OFF_CTRL, 32'h800);
		wr(IRC_OFF_STATUS, 32'h0);
		rd(IRC_OFF_STATUS, 32'h0, 32'h3);
		check("stop_irq", {irq, tx, oe}, 3'b001);
		// Receive capture with reload, both edges, input clock count
		half = 8'd20 + 8'($urandom % 20);
		wr(IRC_OFF_CTRL, 32'h311);
		run <= 1'b1;
		repeat (int'(half) * 6) @(posedge clk_i);
		wb(1'b0, IRC_OFF_MTIME, 32'h0);
		check("capture", 32'(q >= 32'(half) - 1 && q <= 32'(half) + 2), 32'h1);
		// Burst bit rising forces modulation time to one
		run <= 1'b0;
		repeat (10) @(posedge clk_i);
		wr(IRC_OFF_CTRL, 32'h691);
		rd(IRC_OFF_MTIME, 32'h1, 32'hffff);
		// Rising edges counted, then silence flags the start of a space
		wr(IRC_OFF_STATUS, 32'h0);
		run <= 1'b1;
		repeat (int'(half) * 5) @(posedge clk_i);
		run <= 1'b0;
		repeat (100) @(posedge clk_i);
		rd(IRC_OFF_STATUS, 32'h1, 32'h1);
		wb(1'b0, IRC_OFF_MTIME, 32'h0);
		check("burst_cnt", 32'(q > 32'h1), 32'h1);
		// Free-running count from first falling edge must roll over
		wr(IRC_OFF_CTRL, 32'h0);
		wr(IRC_OFF_STATUS, 32'h0);
		wr(IRC_OFF_CTRL, 32'h11);
		run <= 1'b1;
		repeat (int'(half) * 3) @(posedge clk_i);
		run <= 1'b0;
		repeat (66000) @(posedge clk_i);
		rd(IRC_OFF_STATUS, 32'h2, 32'h2);
		summarize();
	end
endmodule
